// File: design/flash_cmd_rom.sv
// command script memory: address and data of each write in a flash command
`timescale 1ns/1ns
module flash_cmd_rom (
    input  wire logic                       sys_clk,
    input  wire logic                       rstn,
    input  wire flash_host_pkg::op_t        op,
    input  wire logic [2:0]                 step,
    input  wire logic [16:0]                user_addr,
    input  wire logic [15:0]                user_data,
    output logic      [16:0]                cyc_addr_q,
    output logic      [15:0]                cyc_data_q,
    output logic      [2:0]                 cyc_count_q
);
    logic [16:0] addr_d;
    logic [15:0] data_d;
    logic [2:0]  count_d;

    // pick the address and data of one step of the chosen sequence
    always_comb begin
        addr_d  = {2'b00, flash_host_pkg::unlock_addr_a};
        data_d  = {8'h00, flash_host_pkg::unlock_data_a};
        count_d = 3'h6;
        case (op)
            flash_host_pkg::op_program:    count_d = 3'h4;
            flash_host_pkg::op_id_entry,
            flash_host_pkg::op_id_exit3:   count_d = 3'h3;
            flash_host_pkg::op_id_exit1:   count_d = 3'h1;
            default:                       count_d = 3'h6;
        endcase
        if (op == flash_host_pkg::op_id_exit1) begin
            addr_d = user_addr;            // any address will do
            data_d = {8'h00, flash_host_pkg::cmd_id_exit};
        end else if (step == 3'h1 || step == 3'h4) begin
            addr_d = {2'b00, flash_host_pkg::unlock_addr_b};
            data_d = {8'h00, flash_host_pkg::unlock_data_b};
        end else if (step == 3'h2) begin
            case (op)
                flash_host_pkg::op_program:  data_d = {8'h00, flash_host_pkg::cmd_program};
                flash_host_pkg::op_id_entry: data_d = {8'h00, flash_host_pkg::cmd_id_entry};
                flash_host_pkg::op_id_exit3: data_d = {8'h00, flash_host_pkg::cmd_id_exit};
                default:                     data_d = {8'h00, flash_host_pkg::cmd_erase_pre};
            endcase
        end else if (step == 3'h3 && op == flash_host_pkg::op_program) begin
            addr_d = user_addr;
            data_d = user_data;
        end else if (step == 3'h5) begin
            case (op)
                flash_host_pkg::op_chip_erase: data_d = {8'h00, flash_host_pkg::cmd_chip_erase};
                flash_host_pkg::op_lockout:    data_d = {8'h00, flash_host_pkg::cmd_lockout};
                default: begin
                    addr_d = user_addr;    // sector select address
                    data_d = {8'h00, flash_host_pkg::cmd_sect_erase};
                end
            endcase
        end
    end

    // registered read port
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cyc_addr_q  <= 17'h00000;
            cyc_data_q  <= 16'h0000;
            cyc_count_q <= 3'h0;
        end else begin
            cyc_addr_q  <= addr_d;
            cyc_data_q  <= data_d;
            cyc_count_q <= count_d;
        end
    end
endmodule

// File: design/flash_host_ctrl.sv
// host controller driving the flash pins, ordered over an AHB-Lite slave
`timescale 1ns/1ns
// Summary of operation
// - command writes use only address bits 14..0 and the low data byte
// - program is four writes AA/5555, 55/2AAA, A0/5555, target; wait 50 us
// - no read is issued while a four-write program sequence runs
// - chip erase is six writes ending 10/5555; wait 200 ms
// - sector erase shares first five writes; sixth is 30 to sector address
// - lockout set is six writes ending 40/5555; wait 200 ms
// - id entry is three writes ending 90/5555; wait 10 us
// - id exit is three writes ending F0/5555, or one F0 anywhere
// - hardware id: strobes for read, id force line raised, others low
// - device drives data only with chip select and output gate low
module flash_host_ctrl #(
    parameter int program_wait = flash_host_pkg::program_cycles,
    parameter int erase_wait   = flash_host_pkg::erase_cycles,
    parameter int id_wait      = flash_host_pkg::id_pause_cycles
) (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic [16:0]      flash_addr,
    output logic [15:0]      flash_dq_out,
    output logic             flash_dq_oe,
    input  wire logic [15:0] flash_dq_in,
    output logic             chip_select_n,
    output logic             output_gate_n,
    output logic             write_strobe_n,
    output logic             reset_n,
    output logic             id_force_hv
);
    logic                    wr_pend_q;
    logic [7:0]              wr_off_q;
    logic                    rd_pend_q;
    logic [7:0]              rd_off_q;
    logic                    go_q;
    flash_host_pkg::op_t     op_q;
    logic                    hwid_q;
    logic                    nowait_q;
    logic [16:0]             user_addr_q;
    logic [15:0]             user_data_q;
    logic [15:0]             rdata_q;
    logic                    busy_q;
    logic                    done_q;
    flash_host_pkg::state_t  state_q;
    logic [2:0]              step_q;
    logic [31:0]             cnt_q;
    logic [15:0]             dq_s1_q;
    logic [15:0]             dq_s2_q;
    logic [16:0]             cyc_addr;
    logic [15:0]             cyc_data;
    logic [2:0]              cyc_count;
    logic                    bus_go;
    logic                    last_step;
    logic [31:0]             pause_len;

    // a write that starts a sequence, taken from the data phase
    assign bus_go = wr_pend_q && wr_off_q == flash_host_pkg::reg_ctrl
                    && hwdata[flash_host_pkg::ctrl_go_pos];
    assign last_step = (step_q + 3'h1) >= cyc_count;

    // pause after the last write, chosen by operation
    function automatic logic [31:0] pause_for(input flash_host_pkg::op_t op);
        case (op)
            flash_host_pkg::op_program:  pause_for = 32'(program_wait);
            flash_host_pkg::op_chip_erase,
            flash_host_pkg::op_sect_erase,
            flash_host_pkg::op_lockout:  pause_for = 32'(erase_wait);
            flash_host_pkg::op_id_entry,
            flash_host_pkg::op_id_exit3,
            flash_host_pkg::op_id_exit1: pause_for = 32'(id_wait);
            default:                     pause_for = 32'h1;
        endcase
    endfunction
    assign pause_len = pause_for(op_q);

    flash_cmd_rom u_rom (
        .sys_clk     (sys_clk),
        .rstn        (rstn),
        .op          (op_q),
        .step        (step_q),
        .user_addr   (user_addr_q),
        .user_data   (user_data_q),
        .cyc_addr_q  (cyc_addr),
        .cyc_data_q  (cyc_data),
        .cyc_count_q (cyc_count)
    );

    // address phase capture; slave is always ready, response okay
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            wr_off_q  <= 8'h00;
            rd_off_q  <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend_q <= hsel && hready && htrans[1] && hwrite;
            rd_pend_q <= hsel && hready && htrans[1] && !hwrite;
            wr_off_q  <= haddr[7:0];
            rd_off_q  <= haddr[7:0];
        end
    end

    // software registers: control, address, write data
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            op_q        <= flash_host_pkg::op_read;
            hwid_q      <= 1'b0;
            nowait_q    <= 1'b0;
            go_q        <= 1'b0;
            user_addr_q <= 17'h00000;
            user_data_q <= 16'h0000;
        end else begin
            go_q <= bus_go && !busy_q;     // orders while busy are dropped
            if (wr_pend_q && !busy_q) begin
                if (wr_off_q == flash_host_pkg::reg_ctrl) begin
                    op_q     <= flash_host_pkg::op_t'(hwdata[flash_host_pkg::ctrl_op_lsb +: 4]);
                    hwid_q   <= hwdata[flash_host_pkg::ctrl_hwid_pos];
                    nowait_q <= hwdata[flash_host_pkg::ctrl_nowait_pos];
                end else if (wr_off_q == flash_host_pkg::reg_addr) begin
                    user_addr_q <= hwdata[16:0];
                end else if (wr_off_q == flash_host_pkg::reg_wdata) begin
                    user_data_q <= hwdata[15:0];
                end
            end
        end
    end

    // read mux; unmapped offsets read zero
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hrdata <= 32'h0000_0000;
        end else if (hsel && hready && htrans[1] && !hwrite) begin
            if (haddr[7:0] == flash_host_pkg::reg_ctrl) begin
                hrdata <= {22'h0, nowait_q, hwid_q, op_q, 4'h0};
            end else if (haddr[7:0] == flash_host_pkg::reg_addr) begin
                hrdata <= {15'h0, user_addr_q};
            end else if (haddr[7:0] == flash_host_pkg::reg_wdata) begin
                hrdata <= {16'h0, user_data_q};
            end else if (haddr[7:0] == flash_host_pkg::reg_rdata) begin
                hrdata <= {16'h0, rdata_q};
            end else if (haddr[7:0] == flash_host_pkg::reg_status) begin
                hrdata <= {30'h0, done_q, busy_q};
            end else begin
                hrdata <= 32'h0000_0000;
            end
        end
    end

    // data pins pass two flip-flops before use
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            dq_s1_q <= 16'h0000;
            dq_s2_q <= 16'h0000;
        end else begin
            dq_s1_q <= flash_dq_in;
            dq_s2_q <= dq_s1_q;
        end
    end

    // pin sequencer: one write cycle per step then the pause, or one read cycle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q        <= flash_host_pkg::st_idle;
            step_q         <= 3'h0;
            cnt_q          <= 32'h0;
            busy_q         <= 1'b0;
            done_q         <= 1'b0;
            rdata_q        <= 16'h0000;
            flash_addr     <= 17'h00000;
            flash_dq_out   <= 16'h0000;
            flash_dq_oe    <= 1'b0;
            chip_select_n  <= 1'b1;
            output_gate_n  <= 1'b1;
            write_strobe_n <= 1'b1;
            reset_n        <= 1'b0;
            id_force_hv    <= 1'b0;
        end else begin
            case (state_q)
                flash_host_pkg::st_idle: begin
                    reset_n <= 1'b1;
                    // clear only a done that the status read showed, so none is lost
                    if (rd_pend_q && rd_off_q == flash_host_pkg::reg_status
                        && hrdata[flash_host_pkg::stat_done_pos]) begin
                        done_q <= 1'b0;
                    end
                    if (go_q) begin
                        busy_q <= 1'b1;
                        done_q <= 1'b0;
                        step_q <= 3'h0;
                        cnt_q  <= 32'h0;
                        if (hwid_q || op_q == flash_host_pkg::op_read) begin
                            state_q <= flash_host_pkg::st_rd;
                        end else begin
                            state_q <= flash_host_pkg::st_setup;
                        end
                    end
                end
                flash_host_pkg::st_setup: begin
                    // rom output settles; address out, output gate high, select and strobe low together
                    cnt_q <= cnt_q + 32'h1;
                    if (cnt_q == 32'h1) begin
                        flash_addr    <= cyc_addr;
                        flash_dq_out  <= cyc_data;
                        flash_dq_oe   <= 1'b1;
                        output_gate_n <= 1'b1;
                        chip_select_n <= 1'b0;
                        write_strobe_n <= 1'b0;
                        cnt_q   <= 32'h0;
                        state_q <= flash_host_pkg::st_wr;
                    end
                end
                flash_host_pkg::st_wr: begin
                    // data stands across the rising strobe edge
                    cnt_q <= cnt_q + 32'h1;
                    if (cnt_q == 32'(flash_host_pkg::strobe_cycles - 1)) begin
                        write_strobe_n <= 1'b1;
                        chip_select_n  <= 1'b1;
                        cnt_q   <= 32'h0;
                        state_q <= flash_host_pkg::st_gap;
                    end
                end
                flash_host_pkg::st_gap: begin
                    // strobe high time; writes follow back to back, no read between
                    cnt_q <= cnt_q + 32'h1;
                    if (cnt_q == 32'(flash_host_pkg::strobe_cycles - 1)) begin
                        flash_dq_oe <= 1'b0;
                        cnt_q       <= 32'h0;
                        if (last_step) begin
                            state_q <= flash_host_pkg::st_wait;
                        end else begin
                            step_q  <= step_q + 3'h1;
                            state_q <= flash_host_pkg::st_setup;
                        end
                    end
                end
                flash_host_pkg::st_wait: begin
                    // pause, cut short when software asks to poll status bits
                    cnt_q <= cnt_q + 32'h1;
                    if (nowait_q || cnt_q >= pause_len - 32'h1) begin
                        busy_q  <= 1'b0;
                        done_q  <= 1'b1;
                        cnt_q   <= 32'h0;
                        state_q <= flash_host_pkg::st_idle;
                    end
                end
                flash_host_pkg::st_rd: begin
                    // read cycle; hardware id raises the force line
                    flash_addr    <= hwid_q ? (user_addr_q & id_addr_mask()) : user_addr_q;
                    id_force_hv   <= hwid_q;
                    flash_dq_oe   <= 1'b0;
                    chip_select_n <= 1'b0;
                    output_gate_n <= 1'b0;
                    cnt_q <= cnt_q + 32'h1;
                    if (cnt_q == 32'(flash_host_pkg::read_cycles + 2)) begin
                        rdata_q        <= dq_s2_q;
                        chip_select_n  <= 1'b1;
                        output_gate_n  <= 1'b1;
                        id_force_hv    <= 1'b0;
                        busy_q         <= 1'b0;
                        done_q         <= 1'b1;
                        cnt_q          <= 32'h0;
                        state_q        <= flash_host_pkg::st_idle;
                    end
                end
                flash_host_pkg::st_rst: begin
                    // hold the reset pin low, all strobes high
                    cnt_q <= cnt_q + 32'h1;
                    if (cnt_q == 32'(flash_host_pkg::reset_cycles - 1)) begin
                        reset_n <= 1'b1;
                        busy_q  <= 1'b0;
                        done_q  <= 1'b1;
                        cnt_q   <= 32'h0;
                        state_q <= flash_host_pkg::st_idle;
                    end
                end
                default: state_q <= flash_host_pkg::st_idle;
            endcase
            if (state_q == flash_host_pkg::st_idle && wr_pend_q
                && wr_off_q == flash_host_pkg::reg_ctrl
                && hwdata[flash_host_pkg::ctrl_reset_pos] && !busy_q) begin
                reset_n <= 1'b0;
                busy_q  <= 1'b1;
                cnt_q   <= 32'h0;
                state_q <= flash_host_pkg::st_rst;
            end
        end
    end

    // hardware id keeps only the select line; other address lines low
    function automatic logic [16:0] id_addr_mask();
        id_addr_mask = flash_host_pkg::id_addr_device;
    endfunction
endmodule

// File: design/flash_host_pkg.sv
// package: command codes, register map and timing for the flash host controller
package flash_host_pkg;
    // flash command addresses and data (low byte and A14..A0 only)
    localparam logic [14:0] unlock_addr_a  = 15'h5555;
    localparam logic [14:0] unlock_addr_b  = 15'h2aaa;
    localparam logic [7:0]  unlock_data_a  = 8'haa;
    localparam logic [7:0]  unlock_data_b  = 8'h55;
    localparam logic [7:0]  cmd_program    = 8'ha0;
    localparam logic [7:0]  cmd_erase_pre  = 8'h80;
    localparam logic [7:0]  cmd_chip_erase = 8'h10;
    localparam logic [7:0]  cmd_sect_erase = 8'h30;
    localparam logic [7:0]  cmd_lockout    = 8'h40;
    localparam logic [7:0]  cmd_id_entry   = 8'h90;
    localparam logic [7:0]  cmd_id_exit    = 8'hf0;
    // sector select addresses (upper five address bits), then id read addresses
    localparam logic [16:0] sector_param1  = 17'h03000;
    localparam logic [16:0] sector_param2  = 17'h05000;
    localparam logic [16:0] sector_main    = 17'h1f000;
    localparam logic [16:0] id_addr_device = 17'h00001;
    localparam logic [16:0] id_addr_lock   = 17'h00002;

    // register byte offsets on the AHB-Lite slave
    localparam logic [7:0] reg_ctrl   = 8'h00;
    localparam logic [7:0] reg_addr   = 8'h04;
    localparam logic [7:0] reg_wdata  = 8'h08;
    localparam logic [7:0] reg_rdata  = 8'h0c;
    localparam logic [7:0] reg_status = 8'h10;

    // control register fields
    localparam int ctrl_go_pos     = 0;
    localparam int ctrl_op_lsb     = 4;
    localparam int ctrl_hwid_pos   = 8;
    localparam int ctrl_nowait_pos = 9;
    localparam int ctrl_reset_pos  = 10;
    // status register fields
    localparam int stat_busy_pos   = 0;
    localparam int stat_done_pos   = 1;

    localparam logic [31:0] ctrl_reset_value = 32'h0000_0000;

    // timing at 250 MHz (4 ns per cycle)
    localparam int clk_period_ns   = 4;
    localparam int strobe_ns       = 100;     // covers 70 ns pulse, 50 ns setup, 100 ns high
    localparam int strobe_cycles   = (strobe_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int read_ns         = 60;      // access time of the slower grade plus margin
    localparam int read_cycles     = (read_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int program_us      = 50;
    localparam int program_cycles  = program_us * 1000 / clk_period_ns;
    localparam int erase_ms        = 200;
    localparam int erase_cycles    = erase_ms * 1000000 / clk_period_ns;
    localparam int id_pause_us     = 10;
    localparam int id_pause_cycles = id_pause_us * 1000 / clk_period_ns;
    localparam int reset_ns        = 500;
    localparam int reset_cycles    = (reset_ns + clk_period_ns - 1) / clk_period_ns;

    // operations requested by software
    typedef enum logic [3:0] {
        op_read       = 4'h0,
        op_program    = 4'h1,
        op_chip_erase = 4'h2,
        op_sect_erase = 4'h3,
        op_lockout    = 4'h4,
        op_id_entry   = 4'h5,
        op_id_exit3   = 4'h6,
        op_id_exit1   = 4'h7
    } op_t;

    // bus cycle sequencer states
    typedef enum logic [2:0] {
        st_idle  = 3'b000,
        st_setup = 3'b001,
        st_wr    = 3'b010,
        st_gap   = 3'b011,
        st_rd    = 3'b100,
        st_wait  = 3'b101,
        st_rst   = 3'b110
    } state_t;
endpackage

// File: test/flash_command_sequencer_bench.sv
// bench: register-driven flash sequences against the device model
`timescale 1ns/1ns
module flash_command_sequencer_bench;
    localparam logic [15:0] mk = 16'h00c3; // arbitrary maker value
    localparam logic [15:0] dv = 16'h005a; // arbitrary device value
    logic        sys_clk, rstn, hwrite, hreadyout, hresp, flash_dq_oe, id_force_hv;
    logic        chip_select_n, output_gate_n, write_strobe_n, reset_n;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [16:0] flash_addr;
    logic [15:0] flash_dq_out, flash_dq_in, dev_dq, d0, d1;
    int          n_fail = 0, n_tests = 0, cyc = 0;
    // 4 ns clock
    initial begin
        sys_clk = 0;
        forever #2 sys_clk = ~sys_clk;
    end
    assign flash_dq_in = flash_dq_oe ? flash_dq_out : dev_dq;
    flash_host_ctrl #(.program_wait(20), .erase_wait(20), .id_wait(20)) i_dut (.sys_clk, .rstn,
        .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_dq_in,
        .chip_select_n, .output_gate_n, .write_strobe_n, .reset_n, .id_force_hv);
    flash_dev_model #(.mk(mk), .dv(dv)) i_dev (.flash_addr, .flash_dq_out, .chip_select_n,
        .output_gate_n, .write_strobe_n, .reset_n, .id_force_hv, .dq(dev_dq));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // hang guard
    always @(posedge sys_clk) if (++cyc == 60000) begin
        n_fail++;
        tally_and_finish();
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic op(input logic [3:0] o, input logic [16:0] a, input logic [15:0] d,
                      input logic [2:0] f = 0);
        ahb(1, flash_host_pkg::reg_addr, {15'h0, a});
        ahb(1, flash_host_pkg::reg_wdata, {16'h0, d});
        ahb(1, flash_host_pkg::reg_ctrl, {21'h0, f, o, 3'h0, 1'b1});
        r = 0;
        repeat (2000) if (r[1] !== 1'b1) ahb(0, flash_host_pkg::reg_status, 0);
        chk("status", 32'h2, r);
    endtask
    task automatic rd(input string nm, input logic [16:0] a, input logic [15:0] e,
                      input logic hw = 0);
        op(0, a, 0, {2'b0, hw});
        ahb(0, flash_host_pkg::reg_rdata, 0);
        chk(nm, {16'h0, e}, r);
    endtask
    initial begin
        {rstn, htrans, haddr, hwrite, hwdata} = '0;
        r = $urandom(64);
        repeat (8) @(posedge sys_clk);
        rstn <= 1;
        @(posedge sys_clk);
        ahb(0, flash_host_pkg::reg_ctrl, 0);
        chk("ctrl", flash_host_pkg::ctrl_reset_value, r);
        ahb(0, 8'h20, 0);
        chk("unmapped", 0, r);
        d0 = 16'($urandom);
        d1 = 16'($urandom);
        op(1, 17'h00010, d0);
        op(1, 17'h1f020, d1);
        rd("main", 17'h1f020, d1);
        op(3, 17'h1f000, 0);
        rd("boot", 17'h00010, 16'hffff);
        op(1, 17'h03010, d0);
        op(1, 17'h05010, d1);
        op(3, 17'h03000, 0);
        rd("par1", 17'h03010, 16'hffff);
        rd("par2", 17'h05010, d1);
        op(3, 17'h05000, 0);
        rd("par2", 17'h05010, 16'hffff);
        $display("test erase done");
        op(5, 0, 0);
        rd("maker", 0, mk);
        rd("dev", 1, dv);
        rd("lock", 2, 0);
        op(7, 17'h1ffff, 0);
        rd("exit", 1, 16'hffff);
        rd("hwid", 1, dv, 1);
        op(1, 17'h00010, d0);
        op(4, 0, 0);
        op(1, 17'h00010, d1);
        op(5, 0, 0);
        rd("lock", 2, 1);
        op(0, 0, 0, 3'h4);
        rd("reset", 17'h00010, d0);
        op(6, 0, 0, 3'h2);
        op(3, 17'h1f000, 0);
        rd("kept", 17'h00010, d0);
        op(1, 17'h1f020, d1);
        op(2, 0, 0);
        rd("chip", 17'h1f020, 16'hffff);
        rd("boot", 17'h00010, d0);
        $display("test id and lockout done");
        tally_and_finish();
    end
endmodule

// File: test/flash_dev_model.sv
// partner: behavioural flash device, one word per 4k page
`timescale 1ns/1ns
module flash_dev_model #(
    parameter logic [15:0] mk = 16'h00c3, // arbitrary maker value
    parameter logic [15:0] dv = 16'h005a  // arbitrary device value
) (
    input  wire logic [16:0] flash_addr,
    input  wire logic [15:0] flash_dq_out,
    input  wire logic        chip_select_n,
    input  wire logic        output_gate_n,
    input  wire logic        write_strobe_n,
    input  wire logic        reset_n,
    input  wire logic        id_force_hv,
    output logic      [15:0] dq
);
    logic [15:0]      m [32];
    logic [5:0][22:0] h = '0;
    logic [22:0]      w;
    logic [16:0]      la;
    logic [15:0]      v;
    logic             idm = 0, lk = 0, pa = 0, sel = 0;
    initial foreach (m[i]) m[i] = 16'hffff;
    // erase scope by sector address and lockout
    task automatic wipe(input logic [4:0] sa, input logic all);
        foreach (m[i]) if ((all || i[4:1] == sa[4:1] || sa == 5'h1f && (i > 5 || i < 2))
            && (i > 1 || !lk)) m[i] = 16'hffff;
    endtask
    // address on falling strobe
    always @(negedge write_strobe_n) begin
        la = flash_addr;
        sel = !chip_select_n;
    end
    // command decode on rising strobe, low byte and a14..a0 only
    always @(posedge write_strobe_n) if (sel && reset_n) begin
        w = {la[14:0], flash_dq_out[7:0]};
        if (pa && (la[16:13] != 0 || !lk)) m[la[16:12]] = flash_dq_out;
        if (w[7:0] == 8'hf0) idm = 0;
        h = pa ? '0 : {h[4:0], w};
        pa = 0;
        if (h[2:1] == {23'h5555aa, 23'h2aaa55} && w[22:8] == 15'h5555) begin
            pa = w[7:0] == 8'ha0;
            if (w[7:0] == 8'h90) idm = 1;
        end
        if (h[5:1] == {23'h5555aa, 23'h2aaa55, 23'h555580, 23'h5555aa, 23'h2aaa55}) begin
            if (w == 23'h555510) wipe(5'h0, 1);
            if (w[7:0] == 8'h30) wipe(la[16:12], 0);
            if (w == 23'h555540) lk = 1;
        end
    end
    // a read or a reset aborts a sequence, reset also leaves id mode
    always @(negedge output_gate_n or negedge reset_n) begin
        h = '0;
        pa = 0;
        if (!reset_n) idm = 0;
    end
    // id codes or array data, inverted when not selected
    always_comb begin
        v = m[flash_addr[16:12]];
        if (idm || id_force_hv && flash_addr[16:1] == 0)
            v = flash_addr[1] ? {15'h0, lk} : flash_addr[0] ? dv : mk;
        dq = (!chip_select_n && !output_gate_n && reset_n) ? v : ~v;
    end
endmodule

// File: test/flash_host_ctrl_asserts.sv
// checker: flash pin relations of the host controller
`timescale 1ns/1ns
module flash_host_ctrl_asserts (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic [16:0] flash_addr,
    input wire logic [15:0] flash_dq_out,
    input wire logic        flash_dq_oe,
    input wire logic        chip_select_n,
    input wire logic        output_gate_n,
    input wire logic        write_strobe_n,
    input wire logic        reset_n,
    input wire logic        id_force_hv
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // write and read strobes never overlap
    AST_WR_GATE: assert property (!write_strobe_n |-> output_gate_n && flash_dq_oe)
        else $error("write with gate low");
    AST_RD_FREE: assert property (!output_gate_n |-> !flash_dq_oe && write_strobe_n)
        else $error("read while driving");
    AST_HOLD: assert property (!write_strobe_n && $past(!write_strobe_n)
        |-> $stable(flash_addr) && $stable(flash_dq_out)) else $error("write not held");
    AST_LOW: assert property ($fell(write_strobe_n) |-> !write_strobe_n[*8])
        else $error("strobe too short");
    AST_HIGH: assert property ($rose(write_strobe_n) |-> write_strobe_n[*8])
        else $error("strobe gap too short");
    AST_CS_WE: assert property ($fell(write_strobe_n) |-> $fell(chip_select_n))
        else $error("select not with strobe");
    AST_HV_RD: assert property (id_force_hv |-> write_strobe_n)
        else $error("write with force line");
    AST_HV_ADR: assert property (id_force_hv && !output_gate_n
        |-> flash_addr[16:1] == 16'h0) else $error("hw id address");
    AST_RST_IDLE: assert property (!reset_n |-> chip_select_n && write_strobe_n)
        else $error("strobe in flash reset");
endmodule
bind flash_host_ctrl flash_host_ctrl_asserts i_chk (.sys_clk, .rstn, .flash_addr,
    .flash_dq_out, .flash_dq_oe, .chip_select_n, .output_gate_n, .write_strobe_n, .reset_n,
    .id_force_hv);
